// ==== rtl/pcu_pkg.sv ====
`default_nettype none

package pcu_pkg;

	// Clock of the unit: 40 MHz, one cycle is 25 ns; the time base is given in these cycles.
	localparam int CLK_PERIOD_NS = 25;
	localparam int CLK_FREQ_HZ = 1000000000 / CLK_PERIOD_NS;

	// Data widths.
	localparam int CNT_W = 32;
	localparam int STAMP_W = 32;
	localparam int SAMPLE_W = CNT_W + STAMP_W;
	localparam int DIO_W = 32;
	localparam int TRIG_N = 8;
	localparam int SEQ_N = 4;
	localparam int GSEL_W = 6;
	localparam int CSEL_W = 7;
	localparam int MODE_W = 3;
	localparam int OP_W = 2;
	localparam int FIFO_DEPTH = 8;

	// Gate source codes: trigger pins from 0, sequencer triggers from 32.
	localparam logic [GSEL_W-1:0] GATE_TRIG_BASE = 6'h00;
	localparam logic [GSEL_W-1:0] GATE_SEQ_BASE = 6'h20;

	// Count source codes: digital I/O bits 0 to 31, trigger pins from 32, sequencer triggers from 64.
	localparam logic [CSEL_W-1:0] CNT_DIO_BASE = 7'h00;
	localparam logic [CSEL_W-1:0] CNT_TRIG_BASE = 7'h20;
	localparam logic [CSEL_W-1:0] CNT_SEQ_BASE = 7'h40;

	// Run modes.
	localparam logic [MODE_W-1:0] MODE_FREE = 3'h1;
	localparam logic [MODE_W-1:0] MODE_GATED_FREE = 3'h2;
	localparam logic [MODE_W-1:0] MODE_GATED = 3'h3;
	localparam logic [MODE_W-1:0] MODE_TAG = 3'h4;

	// Pair arithmetic codes.
	localparam logic [OP_W-1:0] OP_NONE = 2'h0;
	localparam logic [OP_W-1:0] OP_ADD = 2'h1;
	localparam logic [OP_W-1:0] OP_SUB = 2'h2;

	// Values after reset.
	localparam logic [CNT_W-1:0] CNT_RESET = 32'h00000000;
	localparam logic [STAMP_W-1:0] STAMP_RESET = 32'h00000000;
	localparam logic [SAMPLE_W-1:0] SAMPLE_RESET = 64'h0000000000000000;

	// State of the hold-off window in timestamping mode.
	typedef enum logic {
		TAG_IDLE,
		TAG_WINDOW
	} pcu_tag_e;

endpackage : pcu_pkg

`default_nettype wire

// ==== rtl/pcu_top.sv ====
// Behaviour
// R1: Counting runs only while enabled; when disabled all outputs except the result stream read idle, and the stream still drains its buffered words.
// R2: Gate codes 0-7 pick trigger pins, codes from 32 pick sequencer triggers.
// R3: Count codes 0-31 pick I/O bits, 32 up trigger pins, 64 up sequencer triggers.
// R4: With integrate set, results add into a running sum.
// R5: Periodic mode clears the count at the start of each period.
// R6: Periodic mode emits the period's count when the period ends.
// R7: Gate-held periodic mode keeps count and timer cleared while the gate is low.
// R8: Gate-held periodic mode emits only after a full period with the gate high.
// R9: Windowed mode counts only between gate rising and falling edges.
// R10: Windowed mode emits the count at each gate falling edge.
// R11: Timestamping mode stamps the pulse that opens each hold-off window with its time.
// R12: Pulses inside one hold-off window are summed and emitted at its end.
// R13: The period sets both periodic intervals and the timestamping hold-off.
// R14: Arithmetic code 0 passes, 1 adds, 2 subtracts the paired counter output.
// R15: Rising-edge setting counts each low-to-high source transition.
// R16: Falling-edge setting counts high-to-low transitions; both settings count both.
// R17: Every result is held as latest value and pushed to the host stream, unless a full FIFO lets the next result overwrite it.
// R18: Period is a whole number of clock cycles kept by a cycle counter.
// R19: Selected sources are synchronised before edge detection.
`timescale 1ns/10ps
`default_nettype none

module pcu_fifo #(
	parameter int WIDTH = 64,
	parameter int DEPTH = 8
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic resetn,
	// Filling side.
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Draining side.
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0] wr_ptr_r;
	logic [AW-1:0] rd_ptr_r;
	logic [AW:0] fill_r;
	logic push;
	logic load;

	// The output stage is a register, so a word moves into it only when it is empty or being taken.
	assign in_ready = (fill_r != FULL);
	assign push = in_valid && in_ready;
	assign load = (fill_r != '0) && (!out_valid || out_ready);

	// Storage is written at the write index.
	always_ff @(posedge clk) begin
		if (push) begin
			mem_r[wr_ptr_r] <= in_data;
		end
	end

	// Pointers and fill level.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			fill_r <= '0;
		end else begin
			if (push) begin
				wr_ptr_r <= wr_ptr_r + 1'b1;
			end
			if (load) begin
				rd_ptr_r <= rd_ptr_r + 1'b1;
			end
			if (push && !load) begin
				fill_r <= fill_r + 1'b1;
			end else if (!push && load) begin
				fill_r <= fill_r - 1'b1;
			end
		end
	end

	// Output register holds a word until the drain takes it.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			out_valid <= 1'b0;
			out_data <= '0;
		end else if (load) begin
			out_valid <= 1'b1;
			out_data <= mem_r[rd_ptr_r];
		end else if (out_ready) begin
			out_valid <= 1'b0;
		end
	end

endmodule : pcu_fifo

module pcu_top (
	// Clock and reset.
	input wire logic clk,
	input wire logic resetn,
	// Signal sources.
	input wire logic [pcu_pkg::DIO_W-1:0] digital_io,
	input wire logic [pcu_pkg::TRIG_N-1:0] trigger_pin,
	input wire logic [pcu_pkg::SEQ_N-1:0] sequencer_trigger,
	// Settings.
	input wire logic counter_enable,
	input wire logic [pcu_pkg::GSEL_W-1:0] gate_source_select,
	input wire logic [pcu_pkg::CSEL_W-1:0] count_source_select,
	input wire logic accumulate_results,
	input wire logic [pcu_pkg::MODE_W-1:0] run_mode_select,
	input wire logic [pcu_pkg::OP_W-1:0] pair_arithmetic,
	input wire logic [pcu_pkg::CNT_W-1:0] time_base_length,
	input wire logic count_on_fall,
	input wire logic count_on_rise,
	// Paired counter.
	input wire logic [pcu_pkg::CNT_W-1:0] pair_result_in,
	output logic [pcu_pkg::CNT_W-1:0] pair_result_out_r,
	// Results.
	output logic [pcu_pkg::CNT_W-1:0] latest_result_r,
	output logic result_overrun_r,
	// Result stream.
	output logic result_stream_valid,
	input wire logic result_stream_ready,
	output logic [pcu_pkg::SAMPLE_W-1:0] result_stream_data
);
	import pcu_pkg::*;

	// Picks the count source from its select code; unknown codes read low.
	function automatic logic pick_count(input logic [CSEL_W-1:0] sel, input logic [DIO_W-1:0] dio,
		input logic [TRIG_N-1:0] trig, input logic [SEQ_N-1:0] seq);
		logic bit_v;
		bit_v = 1'b0;
		if (sel < CNT_TRIG_BASE) begin
			bit_v = dio[sel[4:0]];
		end else if (sel < CNT_TRIG_BASE + 7'(TRIG_N)) begin
			bit_v = trig[3'(sel - CNT_TRIG_BASE)];
		end else if (sel >= CNT_SEQ_BASE && sel < CNT_SEQ_BASE + 7'(SEQ_N)) begin
			bit_v = seq[2'(sel - CNT_SEQ_BASE)];
		end
		return bit_v;
	endfunction : pick_count

	// Picks the gate source from its select code; unknown codes read low.
	function automatic logic pick_gate(input logic [GSEL_W-1:0] sel, input logic [TRIG_N-1:0] trig,
		input logic [SEQ_N-1:0] seq);
		logic bit_v;
		bit_v = 1'b0;
		if (sel < GATE_TRIG_BASE + 6'(TRIG_N)) begin
			bit_v = trig[3'(sel - GATE_TRIG_BASE)];
		end else if (sel >= GATE_SEQ_BASE && sel < GATE_SEQ_BASE + 6'(SEQ_N)) begin
			bit_v = seq[2'(sel - GATE_SEQ_BASE)];
		end
		return bit_v;
	endfunction : pick_gate

	logic cnt_meta_r;
	logic cnt_sync_r;
	logic cnt_prev_r;
	logic gate_meta_r;
	logic gate_sync_r;
	logic gate_prev_r;
	logic cnt_evt;
	logic gate_rise;
	logic gate_fall;
	logic [CNT_W-1:0] timer_r;
	logic [CNT_W-1:0] period_last;
	logic at_end;
	logic [CNT_W-1:0] count_r;
	logic [CNT_W-1:0] count_inc;
	logic [STAMP_W-1:0] now_r;
	logic [STAMP_W-1:0] stamp_r;
	pcu_tag_e tag_state_r;
	logic emit_now;
	logic [CNT_W-1:0] emit_val;
	logic [STAMP_W-1:0] emit_stamp;
	logic [CNT_W-1:0] acc_r;
	logic [CNT_W-1:0] own_val;
	logic [CNT_W-1:0] final_val;
	logic emit_r;
	logic pend_valid_r;
	logic [SAMPLE_W-1:0] pend_data_r;
	logic fifo_in_ready;

	// Two-stage synchronisers and edge history for the selected sources.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt_meta_r <= 1'b0;
			cnt_sync_r <= 1'b0;
			cnt_prev_r <= 1'b0;
			gate_meta_r <= 1'b0;
			gate_sync_r <= 1'b0;
			gate_prev_r <= 1'b0;
		end else begin
			cnt_meta_r <= pick_count(count_source_select, digital_io, trigger_pin, sequencer_trigger); // R3 R19
			cnt_sync_r <= cnt_meta_r;
			cnt_prev_r <= cnt_sync_r;
			gate_meta_r <= pick_gate(gate_source_select, trigger_pin, sequencer_trigger); // R2 R19
			gate_sync_r <= gate_meta_r;
			gate_prev_r <= gate_sync_r;
		end
	end

	// Count events from the chosen edges; a disabled unit sees none.
	assign cnt_evt = counter_enable && ((count_on_rise && cnt_sync_r && !cnt_prev_r) // R1 R15
		|| (count_on_fall && !cnt_sync_r && cnt_prev_r)); // R16
	assign gate_rise = gate_sync_r && !gate_prev_r;
	assign gate_fall = !gate_sync_r && gate_prev_r;

	// A zero period is taken as one cycle so the time base never stalls.
	assign period_last = (time_base_length == '0) ? '0 : time_base_length - 1'b1; // R13 R18
	assign at_end = (timer_r == period_last);
	assign count_inc = count_r + CNT_W'(cnt_evt);

	// Period timer, the cycle counter behind every time base.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			timer_r <= CNT_RESET;
		end else if (!counter_enable) begin
			timer_r <= CNT_RESET; // R1
		end else begin
			unique case (run_mode_select)
				MODE_FREE: timer_r <= at_end ? CNT_RESET : timer_r + 1'b1; // R18
				MODE_GATED_FREE: timer_r <= (!gate_sync_r || at_end) ? CNT_RESET : timer_r + 1'b1; // R7
				MODE_TAG: timer_r <= (tag_state_r == TAG_WINDOW && !at_end) ? timer_r + 1'b1 : CNT_RESET; // R13
				default: timer_r <= CNT_RESET;
			endcase
		end
	end

	// Hold-off window in timestamping mode: opened by a pulse, closed after one period.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			tag_state_r <= TAG_IDLE;
			stamp_r <= STAMP_RESET;
		end else if (!counter_enable || run_mode_select != MODE_TAG) begin
			tag_state_r <= TAG_IDLE;
		end else begin
			unique case (tag_state_r)
				TAG_IDLE: begin
					if (cnt_evt) begin
						tag_state_r <= TAG_WINDOW;
						stamp_r <= now_r; // R11
					end
				end
				TAG_WINDOW: begin
					if (at_end) begin
						tag_state_r <= TAG_IDLE; // R12
					end
				end
			endcase
		end
	end

	// Free-running time reference used for stamps.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			now_r <= STAMP_RESET;
		end else if (!counter_enable) begin
			now_r <= STAMP_RESET;
		end else begin
			now_r <= now_r + 1'b1;
		end
	end

	// Pulse count for each run mode.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			count_r <= CNT_RESET;
		end else if (!counter_enable) begin
			count_r <= CNT_RESET; // R1
		end else begin
			unique case (run_mode_select)
				MODE_FREE: count_r <= at_end ? CNT_RESET : count_inc; // R5
				MODE_GATED_FREE: count_r <= (!gate_sync_r || at_end) ? CNT_RESET : count_inc; // R7
				MODE_GATED: begin
					if (gate_rise) begin
						count_r <= CNT_W'(cnt_evt); // R9
					end else if (gate_sync_r) begin
						count_r <= count_inc; // R9
					end
				end
				MODE_TAG: begin
					if (tag_state_r == TAG_IDLE) begin
						count_r <= CNT_W'(cnt_evt);
					end else begin
						count_r <= at_end ? CNT_RESET : count_inc; // R12
					end
				end
				default: count_r <= CNT_RESET;
			endcase
		end
	end

	// Decides when a result leaves the counter and with what value and stamp.
	always_comb begin
		emit_now = 1'b0;
		emit_val = count_inc;
		emit_stamp = now_r;
		if (counter_enable) begin
			unique case (run_mode_select)
				MODE_FREE: emit_now = at_end; // R6
				MODE_GATED_FREE: emit_now = gate_sync_r && at_end; // R8
				MODE_GATED: begin
					emit_now = gate_fall; // R10
					emit_val = count_r;
				end
				MODE_TAG: begin
					emit_now = (tag_state_r == TAG_WINDOW) && at_end; // R12
					emit_stamp = stamp_r; // R11
				end
				default: emit_now = 1'b0;
			endcase
		end
	end

	// Integration and pair arithmetic on the emitted value.
	assign own_val = accumulate_results ? acc_r + emit_val : emit_val; // R4
	always_comb begin
		unique case (pair_arithmetic)
			OP_ADD: final_val = own_val + pair_result_in; // R14
			OP_SUB: final_val = own_val - pair_result_in; // R14
			default: final_val = own_val;
		endcase
	end

	// Result registers: running sum, own output for the pair, and the latest value.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			acc_r <= CNT_RESET;
			pair_result_out_r <= CNT_RESET;
			latest_result_r <= CNT_RESET;
			emit_r <= 1'b0;
		end else if (!counter_enable) begin
			acc_r <= CNT_RESET; // R1
			pair_result_out_r <= CNT_RESET;
			latest_result_r <= CNT_RESET;
			emit_r <= 1'b0;
		end else begin
			emit_r <= emit_now;
			if (emit_now) begin
				acc_r <= own_val; // R4
				pair_result_out_r <= own_val;
				latest_result_r <= final_val; // R17
			end
		end
	end

	// One-word holding stage in front of the FIFO; a full FIFO stalls it, a second result overwrites.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pend_valid_r <= 1'b0;
			pend_data_r <= SAMPLE_RESET;
			result_overrun_r <= 1'b0;
		end else begin
			if (emit_now) begin
				pend_valid_r <= 1'b1; // R17
				pend_data_r <= {emit_stamp, final_val};
			end else if (fifo_in_ready) begin
				pend_valid_r <= 1'b0;
			end
			if (emit_now && pend_valid_r && !fifo_in_ready) begin
				result_overrun_r <= 1'b1;
			end else if (!counter_enable) begin
				result_overrun_r <= 1'b0;
			end
		end
	end

	// Stream buffer towards the host.
	pcu_fifo #(
		.WIDTH(SAMPLE_W),
		.DEPTH(FIFO_DEPTH)
	) u_stream_fifo (
		.clk(clk),
		.resetn(resetn),
		.in_valid(pend_valid_r),
		.in_ready(fifo_in_ready),
		.in_data(pend_data_r),
		.out_valid(result_stream_valid),
		.out_ready(result_stream_ready),
		.out_data(result_stream_data)
	);

	// Disabled unit holds the count and the result strobe idle.
	property p_disabled_idle;
		@(posedge clk) disable iff (!resetn)
		!counter_enable |=> (count_r == '0) && !emit_r && (latest_result_r == '0);
	endproperty
	a_disabled_idle: assert property (p_disabled_idle) else $error("disabled unit not idle"); // R1

	// Periodic mode restarts the count at the start of a period.
	property p_free_restart;
		@(posedge clk) disable iff (!resetn)
		counter_enable && run_mode_select == MODE_FREE && at_end ##1 run_mode_select == MODE_FREE
			|-> count_r == '0 && timer_r == '0;
	endproperty
	a_free_restart: assert property (p_free_restart) else $error("period did not restart count"); // R5

	// Periodic mode emits the period's count at its end.
	property p_free_emit;
		@(posedge clk) disable iff (!resetn)
		counter_enable && run_mode_select == MODE_FREE && at_end && !accumulate_results
			&& pair_arithmetic == OP_NONE |=> emit_r && latest_result_r == $past(count_inc);
	endproperty
	a_free_emit: assert property (p_free_emit) else $error("period count not emitted"); // R6

	// Low gate keeps count and timer cleared in gate-held periodic mode.
	property p_gate_low_clear;
		@(posedge clk) disable iff (!resetn)
		counter_enable && run_mode_select == MODE_GATED_FREE && !gate_sync_r |=> count_r == '0 && timer_r == '0;
	endproperty
	a_gate_low_clear: assert property (p_gate_low_clear) else $error("low gate did not clear"); // R7

	// Gate-held periodic results only follow a gate that was high.
	property p_gated_free_emit;
		@(posedge clk) disable iff (!resetn)
		emit_r && $past(run_mode_select) == MODE_GATED_FREE |-> $past(gate_sync_r, 1) && $past(gate_sync_r, 2);
	endproperty
	a_gated_free_emit: assert property (p_gated_free_emit) else $error("emit without a held gate"); // R8

	// Windowed mode freezes the count outside the gate window.
	property p_window_hold;
		@(posedge clk) disable iff (!resetn)
		counter_enable && run_mode_select == MODE_GATED && !gate_sync_r |=> count_r == $past(count_r);
	endproperty
	a_window_hold: assert property (p_window_hold) else $error("count changed outside gate"); // R9

	// Windowed mode emits at the gate falling edge.
	property p_window_emit;
		@(posedge clk) disable iff (!resetn)
		counter_enable && run_mode_select == MODE_GATED && gate_fall |=> emit_r;
	endproperty
	a_window_emit: assert property (p_window_emit) else $error("no result at gate fall"); // R10

	// A tag window lasts exactly one period and then emits.
	property p_tag_window;
		@(posedge clk) disable iff (!resetn)
		counter_enable && run_mode_select == MODE_TAG && tag_state_r == TAG_WINDOW && at_end
			|=> emit_r && tag_state_r == TAG_IDLE;
	endproperty
	a_tag_window: assert property (p_tag_window) else $error("hold-off window not closed"); // R12

	// A rising source edge adds exactly one count in the middle of a period.
	property p_rise_count;
		@(posedge clk) disable iff (!resetn)
		counter_enable && run_mode_select == MODE_FREE && count_on_rise && cnt_sync_r && !cnt_prev_r && !at_end
			|=> count_r == $past(count_r) + 1'b1;
	endproperty
	a_rise_count: assert property (p_rise_count) else $error("rising edge not counted"); // R15

	// Pair subtraction uses the paired counter's output.
	property p_pair_sub;
		@(posedge clk) disable iff (!resetn)
		emit_now && pair_arithmetic == OP_SUB |=> latest_result_r == pair_result_out_r - $past(pair_result_in);
	endproperty
	a_pair_sub: assert property (p_pair_sub) else $error("pair subtraction wrong"); // R14

	// Every result enters the holding stage on the next cycle.
	property p_stream_push;
		@(posedge clk) disable iff (!resetn)
		emit_now |=> pend_valid_r && pend_data_r[CNT_W-1:0] == latest_result_r;
	endproperty
	a_stream_push: assert property (p_stream_push) else $error("result not pushed to stream"); // R17

endmodule : pcu_top

`default_nettype wire

// ==== sim/pcu_source_model.sv ====
`timescale 1ns/10ps
`default_nettype none

module pcu_source_model (
	// Clock.
	input wire logic clk,
	// Source lines towards the unit.
	output logic [pcu_pkg::DIO_W-1:0] digital_io,
	output logic [pcu_pkg::TRIG_N-1:0] trigger_pin,
	output logic [pcu_pkg::SEQ_N-1:0] sequencer_trigger,
	// Host side of the result stream.
	output logic result_stream_ready
);
	import pcu_pkg::*;

	logic toggle_on;
	logic phase;

	// Every line rests low and the host takes words at once unless told to stall.
	initial begin
		digital_io = 32'h00000000;
		trigger_pin = 8'h00;
		sequencer_trigger = 4'h0;
		result_stream_ready = 1'b1;
		toggle_on = 1'b0;
		phase = 1'b0;
	end

	// While enabled, all I/O bits toggle every two cycles, giving one rise per four cycles.
	always @(negedge clk) begin
		phase <= ~phase;
		if (toggle_on && phase) begin
			digital_io <= ~digital_io;
		end
	end

	// Drives one trigger or sequencer line and holds it for two cycles.
	task automatic set_line(input bit seq, input int idx, input logic v);
		if (seq) begin
			sequencer_trigger[idx] = v;
		end else begin
			trigger_pin[idx] = v;
		end
		repeat (2) @(negedge clk);
	endtask : set_line

	// Sends n pulses, each two cycles high and two low.
	task automatic pulses(input bit seq, input int idx, input int n);
		repeat (n) begin
			set_line(seq, idx, 1'b1);
			set_line(seq, idx, 1'b0);
		end
	endtask : pulses

endmodule : pcu_source_model

`default_nettype wire

// ==== sim/tb_pulse_counter_unit.sv ====
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin n_mismatch++; $display("Error %s expected %0h seen %0h", nm, ex, got); end end

module tb_pulse_counter_unit;
	import pcu_pkg::*;

	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic [DIO_W-1:0] dio;
	logic [TRIG_N-1:0] trig;
	logic [SEQ_N-1:0] seqt;
	logic en = 1'b0, integ = 1'b0, rise = 1'b1, fall = 1'b0, ready, valid, overrun;
	logic [GSEL_W-1:0] gsel = 6'h00;
	logic [CSEL_W-1:0] csel = 7'h00;
	logic [MODE_W-1:0] mode = 3'h0;
	logic [OP_W-1:0] op = 2'h0;
	logic [CNT_W-1:0] per = 32'h00000014, pair_in = 32'h00000064, pair_out, latest;
	logic [SAMPLE_W-1:0] data;
	logic [SAMPLE_W-1:0] res_q[$];
	int n_mismatch = 0, total_checks = 0, cyc = 0;

	// Half-period inversion gives 40 MHz.
	always #12.5 clk = ~clk;

	pcu_source_model src (.clk(clk), .digital_io(dio), .trigger_pin(trig), .sequencer_trigger(seqt),
		.result_stream_ready(ready));

	pcu_top uut (.clk(clk), .resetn(resetn), .digital_io(dio), .trigger_pin(trig), .sequencer_trigger(seqt),
		.counter_enable(en), .gate_source_select(gsel), .count_source_select(csel), .accumulate_results(integ),
		.run_mode_select(mode), .pair_arithmetic(op), .time_base_length(per), .count_on_fall(fall),
		.count_on_rise(rise), .pair_result_in(pair_in), .pair_result_out_r(pair_out), .latest_result_r(latest),
		.result_overrun_r(overrun), .result_stream_valid(valid), .result_stream_ready(ready),
		.result_stream_data(data));

	// Collects every word the host takes and counts cycles for stamp checks.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (valid === 1'b1 && ready === 1'b1) begin
			res_q.push_back(data);
		end
	end

	task automatic tally_and_finish;
		$display("Checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : tally_and_finish

	// Disables, lets the stream drain, applies settings and enables again.
	task automatic setup(input logic [2:0] md, input logic [5:0] gs, input logic [6:0] cs, input logic ri, fa, ig,
		input logic [1:0] o, input logic [31:0] p);
		@(negedge clk);
		en = 1'b0;
		repeat (6) @(negedge clk);
		res_q.delete();
		mode = md;
		gsel = gs;
		csel = cs;
		rise = ri;
		fall = fa;
		integ = ig;
		op = o;
		per = p;
		en = 1'b1;
	endtask : setup

	// Waits a bounded time for n stream words.
	task automatic wait_res(input int n);
		for (int i = 0; i < 3000 && res_q.size() < n; i++) @(negedge clk);
		`CHK("word count", 1'b1, res_q.size() >= n)
	endtask : wait_res

	// Periodic mode over two count sources and all three edge settings.
	task automatic t_periodic;
		logic [6:0] cs_t[2] = '{7'h00, 7'h1F};
		src.toggle_on = 1'b1;
		foreach (cs_t[c]) begin
			for (int e = 0; e < 3; e++) begin
				setup(MODE_FREE, 6'h00, cs_t[c], e != 1, e != 0, 1'b0, OP_NONE, 32'h00000014);
				wait_res(3);
				`CHK("period count", (e == 2) ? 32'h0000000A : 32'h00000005, res_q[1][31:0])
				`CHK("next count", (e == 2) ? 32'h0000000A : 32'h00000005, res_q[2][31:0])
				`CHK("period spacing", 32'h00000014, res_q[2][63:32] - res_q[1][63:32])
				`CHK("latest", (e == 2) ? 32'h0000000A : 32'h00000005, latest)
			end
		end
	endtask : t_periodic

	// Running sum and pair arithmetic on top of periodic counting.
	task automatic t_sum_and_pair;
		setup(MODE_FREE, 6'h00, 7'h03, 1'b1, 1'b0, 1'b1, OP_NONE, 32'h00000014);
		wait_res(4);
		`CHK("sum step", 32'h00000005, res_q[3][31:0] - res_q[2][31:0])
		setup(MODE_FREE, 6'h00, 7'h03, 1'b1, 1'b0, 1'b0, OP_ADD, 32'h00000014);
		wait_res(3);
		`CHK("added", 32'h00000069, res_q[2][31:0])
		`CHK("own output", 32'h00000005, pair_out)
		setup(MODE_FREE, 6'h00, 7'h03, 1'b1, 1'b0, 1'b0, OP_SUB, 32'h00000014);
		wait_res(3);
		`CHK("subtracted", 32'hFFFFFFA1, res_q[2][31:0])
		// The spare arithmetic code must pass the own value unchanged.
		setup(MODE_FREE, 6'h00, 7'h03, 1'b1, 1'b0, 1'b0, 2'h3, 32'h00000014);
		wait_res(3);
		`CHK("code three as none", 32'h00000005, res_q[2][31:0])
		// An undefined run mode must stay silent even with a toggling source.
		setup(3'h5, 6'h00, 7'h03, 1'b1, 1'b0, 1'b0, OP_NONE, 32'h00000014);
		repeat (60) @(negedge clk);
		`CHK("idle mode words", 0, res_q.size())
		src.toggle_on = 1'b0;
	endtask : t_sum_and_pair

	// Windowed mode over gate codes at both ends of both ranges.
	task automatic t_windowed;
		logic [5:0] g_t[4] = '{6'h00, 6'h07, 6'h20, 6'h23};
		foreach (g_t[k]) begin
			setup(MODE_GATED, g_t[k], g_t[k][5] ? 7'h21 : 7'h41, 1'b1, 1'b0, 1'b0, OP_NONE, 32'h00000014);
			src.pulses(!g_t[k][5], 1, 2);
			src.set_line(g_t[k][5], g_t[k][2:0], 1'b1);
			src.pulses(!g_t[k][5], 1, 3);
			src.set_line(g_t[k][5], g_t[k][2:0], 1'b0);
			wait_res(1);
			src.pulses(!g_t[k][5], 1, 2);
			repeat (20) @(negedge clk);
			`CHK("window count", 32'h00000003, res_q[0][31:0])
			`CHK("one word per window", 1, res_q.size())
		end
	endtask : t_windowed

	// Gate-held mode: a short gate gives nothing, a long one gives full periods.
	task automatic t_gate_held;
		src.toggle_on = 1'b1;
		setup(MODE_GATED_FREE, 6'h00, 7'h02, 1'b1, 1'b0, 1'b0, OP_NONE, 32'h00000014);
		src.set_line(1'b0, 0, 1'b1);
		repeat (13) @(negedge clk);
		src.set_line(1'b0, 0, 1'b0);
		repeat (30) @(negedge clk);
		`CHK("short gate words", 0, res_q.size())
		src.set_line(1'b0, 0, 1'b1);
		wait_res(2);
		`CHK("first held count", 32'h00000005, res_q[0][31:0])
		`CHK("second held count", 32'h00000005, res_q[1][31:0])
		src.set_line(1'b0, 0, 1'b0);
		src.toggle_on = 1'b0;
	endtask : t_gate_held

	// Timestamping: a burst inside one hold-off window, then a lone pulse.
	task automatic t_tagging;
		int c0;
		setup(MODE_TAG, 6'h00, 7'h20, 1'b1, 1'b0, 1'b0, OP_NONE, 32'h00000028);
		repeat (2) @(negedge clk);
		c0 = cyc;
		src.pulses(1'b0, 0, 3);
		repeat (60) @(negedge clk);
		c0 = cyc - c0;
		src.pulses(1'b0, 0, 1);
		wait_res(2);
		`CHK("burst sum", 32'h00000003, res_q[0][31:0])
		`CHK("lone pulse", 32'h00000001, res_q[1][31:0])
		`CHK("stamp gap", STAMP_W'(c0), res_q[1][63:32] - res_q[0][63:32])
	endtask : t_tagging

	// Host stalls until results overrun, then drains the buffer; disable idles the latest value and the overrun flag.
	task automatic t_stall_and_disable;
		src.result_stream_ready = 1'b0;
		src.toggle_on = 1'b1;
		setup(MODE_FREE, 6'h00, 7'h00, 1'b1, 1'b0, 1'b0, OP_NONE, 32'h00000004);
		repeat (80) @(negedge clk);
		`CHK("overrun", 1'b1, overrun)
		`CHK("stream waiting", 1'b1, valid)
		en = 1'b0;
		src.toggle_on = 1'b0;
		repeat (2) @(negedge clk);
		`CHK("latest idle", 32'h00000000, latest)
		`CHK("overrun idle", 1'b0, overrun)
		src.result_stream_ready = 1'b1;
		repeat (20) @(negedge clk);
		`CHK("drained words", 1'b1, res_q.size() >= 8)
		`CHK("drained value", 32'h00000001, res_q[0][31:0])
		`CHK("stream empty", 1'b0, valid)
	endtask : t_stall_and_disable

	// Reset, then every scenario in turn.
	initial begin
		repeat (6) @(negedge clk);
		resetn = 1'b1;
		@(negedge clk);
		`CHK("reset latest", 32'h00000000, latest)
		`CHK("reset valid", 1'b0, valid)
		t_periodic();
		t_sum_and_pair();
		t_windowed();
		t_gate_held();
		t_tagging();
		t_stall_and_disable();
		tally_and_finish();
	end

	// Cuts a hang short at 20000 cycles, well beyond the roughly 1400 cycles the scenarios need.
	initial begin
		#(25 * 20000);
		n_mismatch++;
		tally_and_finish();
	end

endmodule : tb_pulse_counter_unit

`default_nettype wire
